// >>> logic/psg_gate_ctrl.sv
`timescale 1ns/1ps
`include "psg_regs.svh"
// Functional notes
// - Gates follow PWM only after control supply good for 125 us
// - Control supply loss forces both gates low at once
// - Report is reference until low gate first goes high
// - Overcurrent detection armed only with both supplies good
// - Fault pin released only after both supplies qualified, no faults
// - Both gates low before qualification
// - PWM high drives high gate; PWM low drives low gate if enabled
// - Dead time: gates never high together
// - Middle PWM level held past hold-off forces both gates low
// - Hold-off 40 ns from low, 50 ns from high
// - Leaving middle level resumes PWM control at once
// - Sampling starts 350 ns after falling PWM edge
// - While PWM high, report holds last low-side sample
// - Overcurrent when high-side current trips during high gate
// - Overcurrent cuts high gate at once
// - Overcurrent drives report to fault level
// - Overcurrent clears 1 us after middle level entered
// - Without acknowledge, overcurrent flag and gate block stay
// - Overcurrent pulls fault pin with same timing as report
// - Shorted high switch when node high during low gate
// - Short fault latches report and fault pin until supply reset
// - Short fault blocks high gate; low gate still follows PWM
// - Over-temperature raises temperature flag and pulls fault pin

module psg_gate_ctrl
   import psg_pkg::*;
#(
   parameter int RW = `PSG_REPORT_W,
   parameter int QUAL_NS = `PSG_QUAL_NS
)(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          pwm_high_in,
   input  wire logic          pwm_low_in,
   input  wire logic          low_switch_enable_in,
   input  wire logic          vcc_good_in,
   input  wire logic          vin_good_in,
   input  wire logic          hs_overcurrent_in,
   input  wire logic          switch_node_high_in,
   input  wire logic          ot_rise_in,
   input  wire logic          ot_fall_in,
   input  wire logic [RW-1:0] current_sample_in,
   input  wire logic [RW-1:0] current_reference_in,
   output logic               high_side_gate,
   output logic               low_side_gate,
   output logic [RW-1:0]      current_report_out,
   output logic               temperature_report_out,
   output logic               fault_out,
   output logic               fault_oe_n,
   input  wire logic [7:0]    paddr,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr
);

   // ----------------------------------------
   // Cycle counts
   // ----------------------------------------
   localparam int CK = `PSG_CLK_NS;
   localparam int QUAL_CYC = (QUAL_NS + CK - 1) / CK;
   localparam int HLO_CYC = (`PSG_HOLD_LO_NS + CK - 1) / CK;
   localparam int HHI_CYC = (`PSG_HOLD_HI_NS + CK - 1) / CK;
   localparam int BLK_CYC = (`PSG_BLANK_NS + CK - 1) / CK;
   localparam int CLR_CYC = (`PSG_OC_CLR_NS + CK - 1) / CK;
   localparam int DED_CYC = (`PSG_DEAD_NS + CK - 1) / CK;
   localparam logic [3:0] HOLD_LO = 4'(HLO_CYC);
   localparam logic [3:0] HOLD_HI = 4'(HHI_CYC);
   localparam logic [3:0] BLANK = 4'(BLK_CYC);
   localparam logic [3:0] DEAD = 4'(DED_CYC);
   localparam logic [5:0] CLR_LAST = 6'(CLR_CYC - 1);
   localparam logic [RW-1:0] FLT = RW'(`PSG_FAULT_CODE);

   function automatic logic [RW-1:0] add_sat(
      input logic [RW-1:0] a,
      input logic [RW-1:0] b);
      logic [RW:0] s;
      s = {1'b0, a} + {1'b0, b};
      add_sat = s[RW] ? '1 : s[RW-1:0];
   endfunction

   function automatic logic [3:0] inc4(input logic [3:0] v);
      inc4 = (v == 4'hf) ? v : v + 4'h1;
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Sample bus assumed quiet while sampled; two flops like the rest
   logic [8:0]    pin_s1_reg;
   logic [8:0]    pin_reg;
   logic [RW-1:0] cur_s1_reg;
   logic [RW-1:0] cur_reg;
   logic [RW-1:0] ref_s1_reg;
   logic [RW-1:0] ref_reg;

   always_ff @(posedge clk)
   begin
      pin_s1_reg <= {ot_fall_in, ot_rise_in, switch_node_high_in,
                     hs_overcurrent_in, vin_good_in, vcc_good_in,
                     low_switch_enable_in, pwm_low_in, pwm_high_in};
      pin_reg    <= pin_s1_reg;
      cur_s1_reg <= current_sample_in;
      cur_reg    <= cur_s1_reg;
      ref_s1_reg <= current_reference_in;
      ref_reg    <= ref_s1_reg;
   end

   // Three-level command decoded from the two PWM lines; neither or both high is middle
   wire hi_s   = pin_reg[0] & ~pin_reg[1];
   wire lo_s   = pin_reg[1] & ~pin_reg[0];
   wire mid_s  = ~(hi_s | lo_s);
   wire lsen_s = pin_reg[2];
   wire vcc_s  = pin_reg[3];
   wire vin_s  = pin_reg[4];
   wire oc_s   = pin_reg[5];
   wire sw_s   = pin_reg[6];
   wire otr_s  = pin_reg[7];
   wire otf_s  = pin_reg[8];

   // ----------------------------------------
   // Supply qualification
   // ----------------------------------------
   logic vcc_qual;
   logic vin_qual;

   psg_qual_timer #(.CYCLES(QUAL_CYC)) u_vcc_qual (
      .clk   (clk),
      .rst_n (rst_n),
      .level (vcc_s),
      .done  (vcc_qual)
   );

   psg_qual_timer #(.CYCLES(QUAL_CYC)) u_vin_qual (
      .clk   (clk),
      .rst_n (rst_n),
      .level (vin_s),
      .done  (vin_qual)
   );

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   psg_state_t    st_reg;
   psg_pwm_t      last_reg;
   logic [3:0]    mid_cnt_reg;
   logic [3:0]    low_cnt_reg;
   logic [3:0]    blk_cnt_reg;
   logic [5:0]    clr_cnt_reg;
   logic          hs_reg;
   logic          ls_reg;
   logic          oc_reg;
   logic          sh_reg;
   logic          ot_reg;
   logic          valid_reg;
   logic [RW-1:0] sample_reg;
   logic [RW-1:0] report_reg;
   logic          temp_reg;
   logic          fault_oe_n_reg;
   logic          force_off_reg;
   logic [31:0]   prdata_reg;
   logic          pready_reg;
   logic          pslverr_reg;

   // ----------------------------------------
   // Gate command decode
   // ----------------------------------------
   wire run = (st_reg == PSG_ST_RUN) & vcc_s & ~force_off_reg;
   wire [3:0] hold_cyc = (last_reg == PSG_PWM_HI) ? HOLD_HI
                                                  : HOLD_LO;
   wire tri_off = mid_s & (mid_cnt_reg >= hold_cyc);
   // Inside the hold-off window the last command keeps going
   wire cmd_hi = mid_s ? (last_reg == PSG_PWM_HI) : hi_s;
   wire oc_set = vcc_qual & vin_s & hs_reg & oc_s;
   wire sh_set = ls_reg & sw_s;
   wire hs_block = oc_reg | oc_set | sh_reg;
   wire want_hs = run & ~tri_off & cmd_hi & ~hs_block;
   wire want_ls = run & ~tri_off & ~cmd_hi & lsen_s;
   wire dead_ok = (low_cnt_reg >= DEAD);
   // Turn-on only after the other gate has sat low for the dead time
   wire hs_next = want_hs & ~ls_reg & (hs_reg | dead_ok);
   wire ls_next = want_ls & ~hs_reg & (ls_reg | dead_ok);
   wire [3:0] low_cnt_next = (hs_next | ls_next) ? 4'h0
                                                 : inc4(low_cnt_reg);
   wire [3:0] mid_cnt_next = mid_s ? inc4(mid_cnt_reg) : 4'h0;
   psg_pwm_t last_next;
   assign last_next = mid_s ? last_reg : (hi_s ? PSG_PWM_HI : PSG_PWM_LO);

   // ----------------------------------------
   // Fault decode
   // ----------------------------------------
   wire oc_ack = oc_reg & mid_s;
   wire oc_clr = oc_ack & (clr_cnt_reg == CLR_LAST);
   // A new trip in the clearing cycle wins
   wire oc_next = vcc_s & (oc_set | (oc_reg & ~oc_clr));
   wire [5:0] clr_next = oc_ack ? clr_cnt_reg + 6'h1 : 6'h0;
   // Only a control supply reset clears the short latch
   wire sh_next = vcc_s & (sh_reg | sh_set);
   wire ot_next = otr_s | (ot_reg & ~otf_s);
   wire fault_pull = ~(vcc_qual & vin_qual) | oc_reg | sh_reg
                     | ot_reg;

   // ----------------------------------------
   // Current report
   // ----------------------------------------
   // Samples taken only with the low switch on, past blanking
   wire [3:0] blk_next = hi_s ? 4'h0 : inc4(blk_cnt_reg);
   wire sampling = ~hi_s & ls_reg & (blk_cnt_reg >= BLANK);
   wire valid_next = (st_reg == PSG_ST_RUN) & (valid_reg | ls_reg);
   wire [RW-1:0] sample_next = sampling ? cur_reg : sample_reg;
   wire [RW-1:0] report_next =
      (oc_reg | sh_reg) ? add_sat(ref_reg, FLT) :
      valid_reg ? add_sat(ref_reg, sample_reg) : ref_reg;

   psg_state_t st_next;
   always_comb
   begin
      case (st_reg)
         PSG_ST_OFF: st_next = vcc_qual ? PSG_ST_RUN : PSG_ST_OFF;
         PSG_ST_RUN: st_next = vcc_s ? PSG_ST_RUN : PSG_ST_OFF;
         default:    st_next = PSG_ST_OFF;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_reg      <= PSG_ST_OFF;
         last_reg    <= PSG_PWM_LO;
         mid_cnt_reg <= 4'h0;
         low_cnt_reg <= 4'h0;
         blk_cnt_reg <= 4'h0;
         clr_cnt_reg <= 6'h0;
         hs_reg      <= 1'b0;
         ls_reg      <= 1'b0;
         oc_reg      <= 1'b0;
         sh_reg      <= 1'b0;
         ot_reg      <= 1'b0;
         valid_reg   <= 1'b0;
         sample_reg  <= '0;
         report_reg  <= '0;
         temp_reg    <= 1'b0;
         fault_oe_n_reg <= 1'b0;
      end
      else
      begin
         st_reg      <= st_next;
         last_reg    <= last_next;
         mid_cnt_reg <= mid_cnt_next;
         low_cnt_reg <= low_cnt_next;
         blk_cnt_reg <= blk_next;
         clr_cnt_reg <= clr_next;
         hs_reg      <= hs_next;
         ls_reg      <= ls_next;
         oc_reg      <= oc_next;
         sh_reg      <= sh_next;
         ot_reg      <= ot_next;
         valid_reg   <= valid_next;
         sample_reg  <= sample_next;
         report_reg  <= report_next;
         temp_reg    <= ot_reg;
         fault_oe_n_reg <= ~fault_pull;
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // No wait state: answer is prepared in the setup cycle
   wire setup = psel & ~penable;
   wire acc_wr = psel & penable & pready_reg & pwrite;
   wire hit_ctrl = (paddr == `PSG_CTRL_OFF);
   wire hit_stat = (paddr == `PSG_STATUS_OFF);
   wire hit_smp = (paddr == `PSG_SAMPLE_OFF);
   wire mapped = hit_ctrl | hit_stat | hit_smp;
   wire [31:0] status_w = {25'h0, st_reg == PSG_ST_RUN, valid_reg,
                           ot_reg, sh_reg, oc_reg, vin_qual, vcc_qual};
   wire [31:0] rd_mux = hit_ctrl ? {31'h0, force_off_reg} :
                        hit_stat ? status_w :
                        hit_smp ? {{(32 - RW){1'b0}}, sample_reg} :
                        32'h0000_0000;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         force_off_reg <= 1'(`PSG_CTRL_RST);
         prdata_reg    <= 32'h0000_0000;
         pready_reg    <= 1'b0;
         pslverr_reg   <= 1'b0;
      end
      else
      begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~mapped;
         prdata_reg  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
         if (acc_wr && hit_ctrl)
            force_off_reg <= pwdata[`PSG_CTRL_OFF_B];
      end
   end

   assign high_side_gate         = hs_reg;
   assign low_side_gate          = ls_reg;
   assign current_report_out     = report_reg;
   assign temperature_report_out = temp_reg;
   assign fault_out              = 1'b0;
   assign fault_oe_n             = fault_oe_n_reg;
   assign prdata                 = prdata_reg;
   assign pready                 = pready_reg;
   assign pslverr                = pslverr_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_gate_no_overlap: assert property (
      !(hs_reg && ls_reg))
      else $error("both gates high");

   a_gate_pre_qual: assert property (
      (st_reg == PSG_ST_OFF) |=> !hs_reg && !ls_reg)
      else $error("gate on before qualification");

   a_gate_vcc_loss: assert property (
      !vcc_s |=> !hs_reg && !ls_reg)
      else $error("gate on after supply loss");

   a_tri_force_off: assert property (
      tri_off |=> !hs_reg && !ls_reg)
      else $error("gate on in tri-state");

   a_oc_cut_gate: assert property (
      oc_set |=> !hs_reg [*2])
      else $error("high gate not cut on overcurrent");

   a_oc_report_lvl: assert property (
      oc_reg |=> report_reg == add_sat($past(ref_reg), FLT))
      else $error("report not at fault level");

   a_oc_hold_noack: assert property (
      oc_reg && !mid_s && vcc_s |=> oc_reg)
      else $error("overcurrent dropped without ack");

   a_oc_clear_time: assert property (
      $fell(oc_reg) && vcc_s && $past(vcc_s) |->
         $past(mid_s, 1) && $past(clr_cnt_reg) == CLR_LAST)
      else $error("overcurrent cleared at wrong time");

   a_oc_arm_gate: assert property (
      !vin_s || !vcc_qual |=> !$rose(oc_reg))
      else $error("overcurrent set while unarmed");

   a_short_latch: assert property (
      sh_reg && vcc_s |=> sh_reg)
      else $error("short latch released");

   a_fault_pin: assert property (
      (oc_reg || sh_reg || ot_reg) |=> !fault_oe_n)
      else $error("fault pin not pulled");

   a_temp_flag: assert property (
      $rose(ot_reg) |=> temp_reg)
      else $error("temperature flag late");

endmodule

// >>> logic/psg_pkg.sv
package psg_pkg;

   typedef enum logic [1:0] {
      PSG_PWM_LO,
      PSG_PWM_HI,
      PSG_PWM_MID
   } psg_pwm_t;

   typedef enum logic {
      PSG_ST_OFF,
      PSG_ST_RUN
   } psg_state_t;

endpackage

// >>> logic/psg_qual_timer.sv
`timescale 1ns/1ps

module psg_qual_timer
#(
   parameter int CYCLES = 3125
)(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic level,
   output logic      done
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_reg;
   logic          done_reg;
   wire           reached = (cnt_reg == LAST);

   // ----------------------------------------
   // Level must stay high without a break
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n || !level)
      begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end
      else if (!done_reg)
      begin
         cnt_reg  <= reached ? cnt_reg : cnt_reg + 1'b1;
         done_reg <= reached;
      end
   end

   assign done = done_reg;

endmodule

// >>> logic/psg_regs.svh
`ifndef PSG_REGS_SVH
`define PSG_REGS_SVH

// ----------------------------------------
// Timing, in nanoseconds
// ----------------------------------------
`define PSG_CLK_NS      40
`define PSG_QUAL_NS     125000
`define PSG_HOLD_LO_NS  40
`define PSG_HOLD_HI_NS  50
`define PSG_BLANK_NS    350
`define PSG_OC_CLR_NS   1000
`define PSG_DEAD_NS     40

// ----------------------------------------
// Sizes and levels
// ----------------------------------------
`define PSG_REPORT_W    8
`define PSG_FAULT_CODE  8'h78
`define PSG_ADDR_W      8

// ----------------------------------------
// Register map
// ----------------------------------------
`define PSG_CTRL_OFF    8'h00
`define PSG_STATUS_OFF  8'h04
`define PSG_SAMPLE_OFF  8'h08
`define PSG_CTRL_RST    32'h0000_0000
`define PSG_CTRL_OFF_B  0

`endif

// >>> verif/psg_ctrl_model.sv
`timescale 1ns/1ps
`include "psg_regs.svh"
// ----------
// Controller end of the PWM link
// ----------
module psg_ctrl_model
   import psg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire psg_pwm_t   cmd,
   input  wire logic       ack_en,
   input  wire logic [7:0] report,
   input  wire logic [7:0] ref_code,
   output logic            pwm_high,
   output logic            pwm_low
);
   logic     flagged;
   psg_pwm_t drive;

   assign flagged = (report === ref_code + `PSG_FAULT_CODE);
   // Ack off models a controller that ignores the flag
   assign drive = (ack_en && flagged) ? PSG_PWM_MID : cmd;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pwm_high <= 1'h0;
         pwm_low  <= 1'h0;
      end
      else
      begin
         // Middle level sent as neither line high
         pwm_high <= (drive == PSG_PWM_HI);
         pwm_low  <= (drive == PSG_PWM_LO);
      end
   end
endmodule

// >>> verif/psg_gate_ctrl_tb.sv
`timescale 1ns/1ps
`include "psg_regs.svh"
module psg_gate_ctrl_tb
   import psg_pkg::*;
   ;
   // Short qualification keeps the run brief
   localparam int QNS = 2000;

   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        lsen = 1'h1;
   logic        vcc = 1'h0;
   logic        vin = 1'h0;
   logic        oc = 1'h0;
   logic        swh = 1'h0;
   logic        ot_r = 1'h0;
   logic        ot_f = 1'h0;
   logic        ack = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0]  smp = 8'h00;
   logic [7:0]  refc = 8'h40;
   psg_pwm_t    cmd = PSG_PWM_LO;
   logic        pwm_h;
   logic        pwm_l;
   logic        hg;
   logic        lg;
   logic        tr;
   logic        foe_n;
   logic        fo;
   logic        pready;
   logic        pslverr;
   logic [7:0]  rep;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        er;
   int          err_total = 0;
   int          cmp_count = 0;
   int          cyc_n = 0;

   psg_gate_ctrl #(
      .QUAL_NS (QNS)
   ) i_psg_gate_ctrl (
      .clk                    (clk),
      .rst_n                  (rst_n),
      .pwm_high_in            (pwm_h),
      .pwm_low_in             (pwm_l),
      .low_switch_enable_in   (lsen),
      .vcc_good_in            (vcc),
      .vin_good_in            (vin),
      .hs_overcurrent_in      (oc),
      .switch_node_high_in    (swh),
      .ot_rise_in             (ot_r),
      .ot_fall_in             (ot_f),
      .current_sample_in      (smp),
      .current_reference_in   (refc),
      .high_side_gate         (hg),
      .low_side_gate          (lg),
      .current_report_out     (rep),
      .temperature_report_out (tr),
      .fault_out              (fo),
      .fault_oe_n             (foe_n),
      .paddr                  (paddr),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .pwdata                 (pwdata),
      .prdata                 (prdata),
      .pready                 (pready),
      .pslverr                (pslverr)
   );

   psg_ctrl_model i_psg_ctrl_model (
      .clk      (clk),
      .rst_n    (rst_n),
      .cmd      (cmd),
      .ack_en   (ack),
      .report   (rep),
      .ref_code (refc),
      .pwm_high (pwm_h),
      .pwm_low  (pwm_l)
   );

   always #20 clk = ~clk;

   // ----------
   // Helpers
   // ----------
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 3000)
      begin
         err_total++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask

   // Outputs are read at the edge, before its updates land
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask

   always @(negedge clk)
      if (hg === 1'h1 && lg === 1'h1)
         chk("overlap", 32'h0, 32'h1);

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1)
      begin
         n++;
         @(posedge clk);
      end
      // One access cycle expected; longer waits still complete
      chk("apb wait", 32'h0, n);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   // ----------
   // Scenarios
   // ----------
   task automatic t_power();
      cmd <= PSG_PWM_HI;
      w(30);
      chk("hg early", 1'h0, hg);
      chk("foe early", 1'h0, foe_n);
      vcc <= 1'h1;
      vin <= 1'h1;
      w(30);
      chk("hg qual", 1'h0, hg);
      w(40);
      chk("hg run", 1'h1, hg);
      chk("rep zero", refc, rep);
      chk("foe run", 1'h1, foe_n);
   endtask

   task automatic t_regs();
      apb(1'h0, `PSG_CTRL_OFF, 32'h0);
      chk("ctrl rst", `PSG_CTRL_RST, rd);
      apb(1'h1, `PSG_CTRL_OFF, 32'h1);
      w(6);
      chk("hg forced", 1'h0, hg);
      apb(1'h0, `PSG_CTRL_OFF, 32'h0);
      chk("ctrl rd", 32'h1, rd);
      apb(1'h1, `PSG_CTRL_OFF, 32'h0);
      apb(1'h0, 8'h0C, 32'h0);
      chk("bad err", 1'h1, er);
      chk("bad rd", 32'h0, rd);
      apb(1'h0, `PSG_STATUS_OFF, 32'h0);
      chk("st run", 1'h1, rd[6]);
      chk("st err", 1'h0, er);
   endtask

   task automatic t_decode();
      psg_pwm_t   c [5] = '{PSG_PWM_HI, PSG_PWM_LO, PSG_PWM_LO,
                            PSG_PWM_HI, PSG_PWM_MID};
      logic [2:0] row [5] = '{3'h6, 3'h5, 3'h0, 3'h2, 3'h4};
      for (int i = 0; i < 5; i++)
      begin
         cmd  <= c[i];
         lsen <= row[i][2];
         w(10);
         chk("hg dec", row[i][1], hg);
         chk("lg dec", row[i][0], lg);
      end
   endtask

   task automatic t_holdoff();
      cmd <= PSG_PWM_HI;
      w(10);
      cmd <= PSG_PWM_MID;
      w(2);
      cmd <= PSG_PWM_HI;
      repeat (8)
      begin
         w(1);
         chk("hg blip", 1'h1, hg);
      end
      cmd <= PSG_PWM_MID;
      w(8);
      chk("hg mid", 1'h0, hg);
      cmd <= PSG_PWM_HI;
      w(5);
      chk("hg exit", 1'h1, hg);
      // Same two middle cycles from low must switch off
      cmd <= PSG_PWM_LO;
      w(10);
      cmd <= PSG_PWM_MID;
      w(2);
      cmd <= PSG_PWM_LO;
      w(4);
      chk("lg hold lo", 1'h0, lg);
      w(4);
      chk("lg resume", 1'h1, lg);
   endtask

   task automatic t_sample();
      smp <= 8'h10;
      cmd <= PSG_PWM_LO;
      w(25);
      chk("rep lo", refc + 8'h10, rep);
      cmd <= PSG_PWM_HI;
      w(6);
      smp <= 8'h30;
      w(10);
      chk("rep hold", refc + 8'h10, rep);
      cmd <= PSG_PWM_LO;
      smp <= 8'h20;
      w(8);
      chk("rep blank", refc + 8'h10, rep);
      w(20);
      chk("rep new", refc + 8'h20, rep);
   endtask

   task automatic t_oc_arm();
      vin <= 1'h0;
      cmd <= PSG_PWM_HI;
      w(8);
      oc <= 1'h1;
      w(4);
      chk("hg unarmed", 1'h1, hg);
      chk("foe vin", 1'h0, foe_n);
      oc <= 1'h0;
      w(4);
      vin <= 1'h1;
      w(70);
      chk("foe vin up", 1'h1, foe_n);
   endtask

   task automatic t_oc();
      oc <= 1'h1;
      w(2);
      oc <= 1'h0;
      w(4);
      chk("hg oc", 1'h0, hg);
      chk("rep oc", refc + `PSG_FAULT_CODE, rep);
      chk("foe oc", 1'h0, foe_n);
      chk("fo oc", 1'h0, fo);
      w(40);
      chk("hg stuck", 1'h0, hg);
      chk("rep stuck", refc + `PSG_FAULT_CODE, rep);
      apb(1'h0, `PSG_STATUS_OFF, 32'h0);
      chk("st oc", 1'h1, rd[2]);
      ack <= 1'h1;
      w(15);
      chk("foe ack", 1'h0, foe_n);
      w(30);
      chk("foe clr", 1'h1, foe_n);
      chk("hg back", 1'h1, hg);
      ack <= 1'h0;
   endtask

   task automatic t_short();
      cmd <= PSG_PWM_LO;
      w(10);
      swh <= 1'h1;
      w(2);
      swh <= 1'h0;
      w(4);
      chk("rep short", refc + `PSG_FAULT_CODE, rep);
      chk("foe short", 1'h0, foe_n);
      cmd <= PSG_PWM_HI;
      w(8);
      chk("hg short", 1'h0, hg);
      cmd <= PSG_PWM_LO;
      w(8);
      chk("lg short", 1'h1, lg);
      vcc <= 1'h0;
      w(5);
      chk("lg vcc off", 1'h0, lg);
      vcc <= 1'h1;
      w(70);
      chk("foe por", 1'h1, foe_n);
      chk("lg por", 1'h1, lg);
   endtask

   task automatic t_temp();
      ot_r <= 1'h1;
      w(2);
      ot_r <= 1'h0;
      w(4);
      chk("tmp hi", 1'h1, tr);
      chk("foe tmp", 1'h0, foe_n);
      chk("lg tmp", 1'h1, lg);
      ot_f <= 1'h1;
      w(2);
      ot_f <= 1'h0;
      w(4);
      chk("tmp lo", 1'h0, tr);
      chk("foe cool", 1'h1, foe_n);
   endtask

   // ----------
   // Main sequence
   // ----------
   initial
   begin
      w(4);
      rst_n <= 1'h1;
      t_power();
      t_regs();
      t_decode();
      t_holdoff();
      t_sample();
      t_oc_arm();
      t_oc();
      t_short();
      t_temp();
      wrap_up();
   end
endmodule
